// *** src/calu_unit.sv ***
// cpu arithmetic, logic, shift and bit execution unit with register file
`timescale 1ns/1ps
`default_nettype none
// Function
// - unsigned divide 16/8 and 32/16
// - signed divide, same shapes, two's complement
// - compare sets flags only, destination kept
// - negate replaces destination with zero minus it
// - sign extend byte to word, word to long
// - zero extend byte to word, word to long
// - and with register or immediate
// - or with register or immediate
// - xor with register or immediate
// - not inverts every destination bit
// - arithmetic shifts, right keeps sign
// - logical shifts insert zeros
// - rotate feeds leaving bit to other end
// - rotate through carry, carry in ring
// - bit set, number from immediate or register
// - bit clear, same bit selection
// - bit invert writes back same place
// - bit test loads zero with inverse bit
// - carry and bit, plus inverted variant
// - carry or bit, plus inverted variant
// - inverted carry ops take immediate bit only
// - sizes byte word long, illegal refused
// - eight 32-bit registers, halves and bytes
module calu_unit
  import calu_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire calu_cmd_type cmd,
  input wire logic [2:0] rd_idx,
  output calu_resp_type resp,
  output logic [7:0] condition_code_register,
  output logic [31:0] rd_data
);
  typedef struct packed {
    logic [REG_COUNT-1:0][31:0] greg;
    logic [7:0] condition_code_register;
    logic div_wait;
    logic [2:0] div_dst;
    logic div_word;
    calu_resp_type resp;
    logic [31:0] rd_data;
  } calu_state_type;
  calu_state_type s_reg, s_next;
  calu_div_req_type div_req;
  calu_div_resp_type div_resp;
  logic [31:0] d_full, s_full, d_op, s_op, res, msk, sgn;
  logic [32:0] diff;
  logic [7:0] byte_op, bit_mask;
  logic [2:0] bit_no;
  logic sel_bit, size_ok, wr_dst, c_out, c_new, c_set, v_new, bit_ok;
  logic [4:0] msb;

  calu_divider u_div (
    .mclk(mclk),
    .reset(reset),
    .req(div_req),
    .resp(div_resp)
  );

  // read an operand as byte (rNh/rNl), word (eN/rN chosen by hi) or long
  function automatic logic [31:0] read_op(input logic [31:0] r,
      input calu_size_type sz, input logic hi);
    logic [31:0] v;
    v = r;
    unique case (sz)
      CALU_SZ_B: v = {24'h00_0000, hi ? r[15:8] : r[7:0]};
      CALU_SZ_W: v = {16'h0000, hi ? r[31:16] : r[15:0]};
      default: v = r;
    endcase
    return v;
  endfunction

  // merge a result back into the addressed part of a register
  function automatic logic [31:0] merge(input logic [31:0] r,
      input logic [31:0] v, input calu_size_type sz, input logic hi);
    logic [31:0] o;
    o = r;
    unique case (sz)
      CALU_SZ_B: if (hi) o[15:8] = v[7:0]; else o[7:0] = v[7:0];
      CALU_SZ_W: if (hi) o[31:16] = v[15:0]; else o[15:0] = v[15:0];
      default: o = v;
    endcase
    return o;
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.resp.done = 1'b0;
    s_next.resp.error = 1'b0;
    s_next.resp.mem_we = 1'b0;
    s_next.rd_data = s_reg.greg[rd_idx];
    div_req = '0;
    d_full = s_reg.greg[cmd.dst_idx];
    s_full = s_reg.greg[cmd.src_idx];
    d_op = read_op(d_full, cmd.size, cmd.dst_hi);
    s_op = cmd.use_imm ? cmd.imm : read_op(s_full, cmd.size, cmd.src_hi);
    msb = (cmd.size == CALU_SZ_B) ? 5'd7 :
          (cmd.size == CALU_SZ_W) ? 5'd15 : 5'd31;
    msk = (cmd.size == CALU_SZ_B) ? 32'h0000_00ff :
          (cmd.size == CALU_SZ_W) ? 32'h0000_ffff : 32'hffff_ffff;
    sgn = 32'h0000_0001 << msb;
    s_op = s_op & msk;
    res = d_op;
    diff = 33'h0_0000_0000;
    wr_dst = 1'b0;
    c_set = 1'b0;
    c_out = s_reg.condition_code_register[CCR_C];
    v_new = 1'b0;
    c_new = s_reg.condition_code_register[CCR_C];
    byte_op = cmd.mem_op ? cmd.mem_byte : d_op[7:0];
    // register bit numbers use only the low three bits
    bit_no = cmd.bit_from_reg ? s_full[2:0] : cmd.imm[2:0];
    bit_mask = 8'h01 << bit_no;
    sel_bit = byte_op[bit_no];
    unique case (cmd.op)
      CALU_DIVIDE_UNSIGNED, CALU_DIVIDE_SIGNED:
        size_ok = (cmd.size == CALU_SZ_B) || (cmd.size == CALU_SZ_W);
      CALU_SIGN_EXTEND_OP, CALU_ZERO_EXTEND_OP:
        size_ok = (cmd.size == CALU_SZ_W) || (cmd.size == CALU_SZ_L);
      CALU_BIT_SET_OP, CALU_BIT_CLEAR_OP, CALU_BIT_INVERT_OP,
      CALU_BIT_TEST_OP, CALU_CARRY_AND_BIT, CALU_CARRY_OR_BIT:
        size_ok = (cmd.size == CALU_SZ_B);
      CALU_CARRY_AND_INV_BIT, CALU_CARRY_OR_INV_BIT:
        size_ok = (cmd.size == CALU_SZ_B) && !cmd.bit_from_reg;
      default: size_ok = (cmd.size != CALU_SZ_BAD);
    endcase
    bit_ok = size_ok;
    if (s_reg.div_wait) begin
      if (div_resp.done) begin
        // quotient low, remainder high in the destination
        if (s_reg.div_word)
          s_next.greg[s_reg.div_dst] = {div_resp.rem, div_resp.quot};
        else
          s_next.greg[s_reg.div_dst][15:0] =
            {div_resp.rem[7:0], div_resp.quot[7:0]};
        s_next.condition_code_register[CCR_Z] = div_resp.zero_div ? 1'b1 :
          (s_reg.div_word ? div_resp.quot == 16'h0000
                          : div_resp.quot[7:0] == 8'h00);
        s_next.condition_code_register[CCR_N] = s_reg.div_word ? div_resp.quot[15]
                                           : div_resp.quot[7];
        s_next.div_wait = 1'b0;
        s_next.resp.busy = 1'b0;
        s_next.resp.done = 1'b1;
      end
    end else if (cmd_valid) begin
      s_next.resp.done = 1'b1;
      if (!bit_ok) begin
        s_next.resp.error = 1'b1;
      end else begin
        unique case (cmd.op)
          CALU_DIVIDE_UNSIGNED, CALU_DIVIDE_SIGNED: begin
            div_req.start = 1'b1;
            div_req.is_word = (cmd.size == CALU_SZ_W);
            div_req.is_signed = (cmd.op == CALU_DIVIDE_SIGNED);
            div_req.dividend = (cmd.size == CALU_SZ_W) ? d_full
                               : {16'h0000, d_full[15:0]};
            div_req.divisor = (cmd.size == CALU_SZ_W) ? s_full[15:0]
                              : {8'h00, cmd.src_hi ? s_full[15:8]
                                                   : s_full[7:0]};
            s_next.div_wait = 1'b1;
            s_next.div_dst = cmd.dst_idx;
            s_next.div_word = (cmd.size == CALU_SZ_W);
            s_next.resp.busy = 1'b1;
            s_next.resp.done = 1'b0;
          end
          CALU_COMPARE_OP, CALU_NEGATE_OP: begin
            diff = (cmd.op == CALU_NEGATE_OP) ? 33'(0) - {1'b0, d_op}
                   : {1'b0, d_op} - {1'b0, s_op};
            res = diff[31:0] & msk;
            c_set = 1'b1;
            c_out = |(diff[31:0] & ~msk) || diff[32];
            v_new = (cmd.op == CALU_NEGATE_OP)
              ? (d_op == sgn)
              : (|((d_op ^ s_op) & (d_op ^ res) & sgn));
            wr_dst = (cmd.op == CALU_NEGATE_OP);
          end
          CALU_SIGN_EXTEND_OP: begin
            res = (cmd.size == CALU_SZ_W) ? {{24{d_op[7]}}, d_op[7:0]}
                  : {{16{d_op[15]}}, d_op[15:0]};
            wr_dst = 1'b1;
          end
          CALU_ZERO_EXTEND_OP: begin
            res = (cmd.size == CALU_SZ_W) ? {24'h00_0000, d_op[7:0]}
                  : {16'h0000, d_op[15:0]};
            wr_dst = 1'b1;
          end
          CALU_AND_OP: begin res = d_op & s_op; wr_dst = 1'b1; end
          CALU_OR_OP: begin res = d_op | s_op; wr_dst = 1'b1; end
          CALU_XOR_OP: begin res = d_op ^ s_op; wr_dst = 1'b1; end
          CALU_NOT_OP: begin res = ~d_op & msk; wr_dst = 1'b1; end
          CALU_ARITH_SHIFT_LEFT, CALU_LOGIC_SHIFT_LEFT,
          CALU_ROTATE_LEFT, CALU_ROTATE_LEFT_VIA_CARRY: begin
            // single position per instruction
            c_out = |(d_op & sgn);
            c_set = 1'b1;
            res = (d_op << 1) & msk;
            if (cmd.op == CALU_ROTATE_LEFT) res[0] = c_out;
            if (cmd.op == CALU_ROTATE_LEFT_VIA_CARRY)
              res[0] = s_reg.condition_code_register[CCR_C];
            if (cmd.op == CALU_ARITH_SHIFT_LEFT)
              v_new = c_out ^ (|(res & sgn));
            wr_dst = 1'b1;
          end
          CALU_ARITH_SHIFT_RIGHT, CALU_LOGIC_SHIFT_RIGHT,
          CALU_ROTATE_RIGHT, CALU_ROTATE_RIGHT_VIA_CARRY: begin
            c_out = d_op[0];
            c_set = 1'b1;
            res = d_op >> 1;
            if (cmd.op == CALU_ARITH_SHIFT_RIGHT)
              res = res | (d_op & sgn);
            if (cmd.op == CALU_ROTATE_RIGHT && d_op[0])
              res = res | sgn;
            if (cmd.op == CALU_ROTATE_RIGHT_VIA_CARRY && s_reg.condition_code_register[CCR_C])
              res = res | sgn;
            wr_dst = 1'b1;
          end
          CALU_BIT_SET_OP, CALU_BIT_CLEAR_OP, CALU_BIT_INVERT_OP: begin
            unique case (cmd.op)
              CALU_BIT_SET_OP: byte_op = byte_op | bit_mask;
              CALU_BIT_CLEAR_OP: byte_op = byte_op & ~bit_mask;
              default: byte_op = byte_op ^ bit_mask;
            endcase
            res = {24'h00_0000, byte_op};
            wr_dst = !cmd.mem_op;
            s_next.resp.mem_we = cmd.mem_op;
            s_next.resp.mem_wdata = byte_op;
          end
          CALU_BIT_TEST_OP: s_next.condition_code_register[CCR_Z] = ~sel_bit;
          CALU_CARRY_AND_BIT, CALU_CARRY_AND_INV_BIT: begin
            c_new = s_reg.condition_code_register[CCR_C] &
              (sel_bit ^ (cmd.op == CALU_CARRY_AND_INV_BIT));
            s_next.condition_code_register[CCR_C] = c_new;
          end
          CALU_CARRY_OR_BIT, CALU_CARRY_OR_INV_BIT: begin
            c_new = s_reg.condition_code_register[CCR_C] |
              (sel_bit ^ (cmd.op == CALU_CARRY_OR_INV_BIT));
            s_next.condition_code_register[CCR_C] = c_new;
          end
        endcase
        if (wr_dst)
          s_next.greg[cmd.dst_idx] =
            merge(d_full, res, cmd.size, cmd.dst_hi);
        if (c_set) begin
          // flags from every compare, negate, shift and rotate result
          s_next.condition_code_register[CCR_C] = c_out;
          s_next.condition_code_register[CCR_V] = v_new;
          s_next.condition_code_register[CCR_Z] = ((res & msk) == 32'h0000_0000);
          s_next.condition_code_register[CCR_N] = |(res & sgn);
        end else if (wr_dst) begin
          s_next.condition_code_register[CCR_V] = 1'b0;
          s_next.condition_code_register[CCR_Z] = ((res & msk) == 32'h0000_0000);
          s_next.condition_code_register[CCR_N] = |(res & sgn);
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.condition_code_register <= CCR_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign resp = s_reg.resp;
  assign condition_code_register = s_reg.condition_code_register;
  assign rd_data = s_reg.rd_data;

  chk_compare_keeps_dst: assert property (@(posedge mclk) disable iff (reset)
    (cmd_valid && !s_reg.div_wait && cmd.op == CALU_COMPARE_OP)
      |=> s_reg.greg == $past(s_reg.greg))
    else $error("compare changed a register");
  chk_bit_test_zero: assert property (@(posedge mclk) disable iff (reset)
    (cmd_valid && !s_reg.div_wait && bit_ok && !cmd.mem_op &&
     cmd.op == CALU_BIT_TEST_OP) |=> condition_code_register[CCR_Z] == !$past(sel_bit))
    else $error("bit test zero flag wrong");
  chk_inv_imm_only: assert property (@(posedge mclk) disable iff (reset)
    (cmd_valid && !s_reg.div_wait && cmd.bit_from_reg &&
     cmd.op == CALU_CARRY_OR_INV_BIT) |=> resp.error)
    else $error("inverted carry op accepted register bit number");
  chk_bad_size: assert property (@(posedge mclk) disable iff (reset)
    (cmd_valid && !s_reg.div_wait && cmd.size == CALU_SZ_L &&
     cmd.op == CALU_DIVIDE_UNSIGNED) |=> resp.error && !resp.busy)
    else $error("long divide not refused");
  chk_not_result: assert property (@(posedge mclk) disable iff (reset)
    (cmd_valid && !s_reg.div_wait && cmd.op == CALU_NOT_OP &&
     cmd.size == CALU_SZ_L) |=>
      s_reg.greg[$past(cmd.dst_idx)] == ~$past(d_full))
    else $error("complement result wrong");
  chk_shift_carry: assert property (@(posedge mclk) disable iff (reset)
    (cmd_valid && !s_reg.div_wait && bit_ok &&
     cmd.op == CALU_LOGIC_SHIFT_RIGHT) |=> condition_code_register[CCR_C] == $past(d_op[0]))
    else $error("shift out bit not in carry");
  chk_div_busy: assert property (@(posedge mclk) disable iff (reset)
    $rose(resp.busy) |-> ##[1:17] resp.done)
    else $error("divide did not complete");
  chk_sext_long: assert property (@(posedge mclk) disable iff (reset)
    (cmd_valid && !s_reg.div_wait && cmd.op == CALU_SIGN_EXTEND_OP &&
     cmd.size == CALU_SZ_L) |=>
      s_reg.greg[$past(cmd.dst_idx)][31:16] == {16{$past(d_full[15])}})
    else $error("sign extension wrong");
endmodule
`default_nettype wire

// *** pkg/calu_pkg.sv ***
// shared types and constants for the cpu arithmetic/logic/bit unit
package calu_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_COUNT = 8;
  localparam int unsigned DIV_STEPS_WORD = 16;
  localparam int unsigned DIV_STEPS_BYTE = 8;
  localparam logic [31:0] GREG_RESET = 32'h0000_0000;
  localparam logic [7:0] CCR_RESET = 8'h80;
  localparam int unsigned CCR_C = 0;
  localparam int unsigned CCR_V = 1;
  localparam int unsigned CCR_Z = 2;
  localparam int unsigned CCR_N = 3;

  typedef enum logic [1:0] {
    CALU_SZ_B,
    CALU_SZ_W,
    CALU_SZ_L,
    CALU_SZ_BAD
  } calu_size_type;

  typedef enum logic [4:0] {
    CALU_DIVIDE_UNSIGNED,
    CALU_DIVIDE_SIGNED,
    CALU_COMPARE_OP,
    CALU_NEGATE_OP,
    CALU_SIGN_EXTEND_OP,
    CALU_ZERO_EXTEND_OP,
    CALU_AND_OP,
    CALU_OR_OP,
    CALU_XOR_OP,
    CALU_NOT_OP,
    CALU_ARITH_SHIFT_LEFT,
    CALU_ARITH_SHIFT_RIGHT,
    CALU_LOGIC_SHIFT_LEFT,
    CALU_LOGIC_SHIFT_RIGHT,
    CALU_ROTATE_LEFT,
    CALU_ROTATE_RIGHT,
    CALU_ROTATE_LEFT_VIA_CARRY,
    CALU_ROTATE_RIGHT_VIA_CARRY,
    CALU_BIT_SET_OP,
    CALU_BIT_CLEAR_OP,
    CALU_BIT_INVERT_OP,
    CALU_BIT_TEST_OP,
    CALU_CARRY_AND_BIT,
    CALU_CARRY_AND_INV_BIT,
    CALU_CARRY_OR_BIT,
    CALU_CARRY_OR_INV_BIT
  } calu_op_type;

  // one instruction as handed over by the decoder
  typedef struct packed {
    calu_op_type op;
    calu_size_type size;
    logic [2:0] dst_idx;
    logic dst_hi;
    logic [2:0] src_idx;
    logic src_hi;
    logic use_imm;
    logic [31:0] imm;
    logic bit_from_reg;
    logic mem_op;
    logic [7:0] mem_byte;
  } calu_cmd_type;

  typedef struct packed {
    logic busy;
    logic done;
    logic error;
    logic mem_we;
    logic [7:0] mem_wdata;
  } calu_resp_type;

  typedef struct packed {
    logic start;
    logic is_word;
    logic is_signed;
    logic [31:0] dividend;
    logic [15:0] divisor;
  } calu_div_req_type;

  typedef struct packed {
    logic done;
    logic zero_div;
    logic [15:0] quot;
    logic [15:0] rem;
  } calu_div_resp_type;
endpackage

// *** src/calu_divider.sv ***
// iterative restoring divider, 16/8 and 32/16, signed or unsigned
`timescale 1ns/1ps
`default_nettype none
module calu_divider
  import calu_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire calu_div_req_type req,
  output calu_div_resp_type resp
);
  typedef enum logic {DV_IDLE, DV_RUN} calu_dv_state_type;
  typedef struct packed {
    calu_dv_state_type st;
    logic [4:0] cnt;
    logic is_word;
    logic neg_q;
    logic neg_r;
    logic [31:0] rem_quo;
    logic [15:0] dvs;
    calu_div_resp_type out;
  } calu_dv_type;
  calu_dv_type s_reg, s_next;
  logic [31:0] dd_abs;
  logic [15:0] dv_abs;
  logic [16:0] trial;
  logic [15:0] q, r;

  always_comb begin
    s_next = s_reg;
    s_next.out.done = 1'b0;
    dd_abs = req.dividend;
    dv_abs = req.divisor;
    trial = 17'h0_0000;
    q = 16'h0000;
    r = 16'h0000;
    unique case (s_reg.st)
      DV_IDLE: begin
        if (req.start) begin
          if (req.is_signed) begin
            if (req.is_word && req.dividend[31]) dd_abs = -req.dividend;
            if (!req.is_word && req.dividend[15])
              dd_abs = {16'h0000, 16'(-req.dividend[15:0])};
            if (req.is_word && req.divisor[15]) dv_abs = -req.divisor;
            if (!req.is_word && req.divisor[7])
              dv_abs = {8'h00, 8'(-req.divisor[7:0])};
          end
          s_next.is_word = req.is_word;
          s_next.neg_r = req.is_signed &&
            (req.is_word ? req.dividend[31] : req.dividend[15]);
          s_next.neg_q = s_next.neg_r ^ (req.is_signed &&
            (req.is_word ? req.divisor[15] : req.divisor[7]));
          s_next.dvs = req.is_word ? dv_abs : {8'h00, dv_abs[7:0]};
          // byte shape starts the remainder half with the high dividend
          // byte, so both shapes share one 17-bit trial subtract
          s_next.rem_quo = req.is_word ? dd_abs
                                       : {8'h00, dd_abs[15:0], 8'h00};
          s_next.cnt = req.is_word ? 5'(DIV_STEPS_WORD)
                                   : 5'(DIV_STEPS_BYTE);
          s_next.out.zero_div = req.is_word ? (req.divisor == 16'h0000)
                                            : (req.divisor[7:0] == 8'h00);
          s_next.st = DV_RUN;
        end
      end
      DV_RUN: begin
        trial = s_reg.rem_quo[31:15] - {1'b0, s_reg.dvs};
        if (!trial[16] || (s_reg.is_word && s_reg.rem_quo[31]))
          s_next.rem_quo = {trial[15:0], s_reg.rem_quo[14:0], 1'b1};
        else
          s_next.rem_quo = {s_reg.rem_quo[30:0], 1'b0};
        s_next.cnt = s_reg.cnt - 5'h01;
        if (s_reg.cnt == 5'h01) begin
          if (s_reg.is_word) begin
            q = s_next.rem_quo[15:0];
            r = s_next.rem_quo[31:16];
          end else begin
            q = {8'h00, s_next.rem_quo[7:0]};
            r = {8'h00, s_next.rem_quo[23:16]};
          end
          if (s_reg.neg_q) q = s_reg.is_word ? -q : {8'h00, 8'(-q[7:0])};
          if (s_reg.neg_r) r = s_reg.is_word ? -r : {8'h00, 8'(-r[7:0])};
          s_next.out.quot = q;
          s_next.out.rem = r;
          s_next.out.done = 1'b1;
          s_next.st = DV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign resp = s_reg.out;

  chk_div_done_len: assert property (@(posedge mclk) disable iff (reset)
    (s_reg.st == DV_IDLE && req.start && !req.is_word) |->
      ##9 resp.done)
    else $error("byte divide did not finish in eight cycles");
endmodule
`default_nettype wire

// *** testbench/calu_dec_model.sv ***
// decoder-side model: hands the unit one instruction at a time
`timescale 1ns/1ps
`default_nettype none
module calu_dec_model
  import calu_pkg::*;
(
  input wire logic mclk,
  input wire calu_resp_type resp,
  output var logic cmd_valid,
  output var calu_cmd_type cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end

  // held until the taking edge, then the bus shows junk so a late
  // sample inside the unit cannot pass by luck
  task automatic issue(input calu_cmd_type c, output calu_resp_type rs);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd <= calu_cmd_type'(~c);
    do begin
      @(posedge mclk);
      n++;
    end while (resp.done !== 1'b1 && n < 40);
    rs = resp;
  endtask
endmodule
`default_nettype wire

// *** testbench/test_calu_unit.sv ***
// self-checking bench for the arithmetic, logic and bit unit
`timescale 1ns/1ps
`default_nettype none
module test_calu_unit
  import calu_pkg::*;
();
  logic mclk;
  logic reset;
  logic cmd_valid;
  logic [2:0] rd_idx;
  calu_cmd_type cmd;
  calu_resp_type resp;
  calu_resp_type rs;
  logic [7:0] condition_code_register;
  logic [31:0] rd_data;
  logic [31:0] m_reg [8];
  logic mc;
  int mismatches;
  int num_checks;

  calu_unit uut (
    .mclk(mclk),
    .reset(reset),
    .cmd_valid(cmd_valid),
    .cmd(cmd),
    .rd_idx(rd_idx),
    .resp(resp),
    .condition_code_register(condition_code_register),
    .rd_data(rd_data)
  );
  calu_dec_model dec (
    .mclk(mclk),
    .resp(resp),
    .cmd_valid(cmd_valid),
    .cmd(cmd)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk_val(string what, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_bit(string what, logic e, logic g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic calu_cmd_type base(calu_op_type op, int sz, int d);
    calu_cmd_type c;
    c = '0;
    c.op = op;
    c.size = calu_size_type'(sz);
    c.dst_idx = 3'(d);
    return c;
  endfunction

  // field of width w at offset off; other bits of the register kept
  task automatic ref_op(calu_op_type op, int w, int off, logic [31:0] a,
      logic [31:0] b, output logic [31:0] r, output logic co);
    logic [31:0] m, x, t;
    m = (w == 32) ? 32'hffff_ffff : (32'h1 << w) - 32'h1;
    t = 32'h1 << (w - 1);
    x = (a >> off) & m;
    co = mc;
    // right-going shift codes are the odd ones
    if (op >= CALU_ARITH_SHIFT_LEFT) co = op[0] ? x[0] : |(x & t);
    case (op)
      CALU_AND_OP: x = x & b;
      CALU_OR_OP: x = x | b;
      CALU_XOR_OP: x = x ^ b;
      CALU_NOT_OP: x = ~x;
      CALU_NEGATE_OP: begin
        co = (x != 32'h0);
        x = 32'h0 - x;
      end
      CALU_ARITH_SHIFT_RIGHT: x = (x >> 1) | (x & t);
      CALU_LOGIC_SHIFT_RIGHT: x = x >> 1;
      CALU_ROTATE_RIGHT: x = (x >> 1) | (x[0] ? t : 32'h0);
      CALU_ROTATE_RIGHT_VIA_CARRY: x = (x >> 1) | (mc ? t : 32'h0);
      CALU_ROTATE_LEFT: x = (x << 1) | 32'(co);
      CALU_ROTATE_LEFT_VIA_CARRY: x = (x << 1) | 32'(mc);
      default: x = x << 1;
    endcase
    r = (a & ~(m << off)) | ((x & m) << off);
  endtask

  task automatic chkreg(int d);
    rd_idx <= 3'(d);
    @(posedge mclk);
    @(posedge mclk);
    chk_val("register", m_reg[d], rd_data);
  endtask

  // no load op exists: clear with and, then or in the value
  task automatic setr(int d, logic [31:0] v);
    calu_cmd_type c;
    c = base(CALU_AND_OP, 2, d);
    c.use_imm = 1'b1;
    dec.issue(c, rs);
    c.op = CALU_OR_OP;
    c.imm = v;
    dec.issue(c, rs);
    m_reg[d] = v;
  endtask

  initial begin
    calu_op_type ops [12] = '{CALU_AND_OP, CALU_OR_OP, CALU_XOR_OP,
      CALU_NOT_OP, CALU_ARITH_SHIFT_LEFT, CALU_ARITH_SHIFT_RIGHT,
      CALU_LOGIC_SHIFT_LEFT, CALU_LOGIC_SHIFT_RIGHT, CALU_ROTATE_LEFT,
      CALU_ROTATE_RIGHT, CALU_ROTATE_LEFT_VIA_CARRY,
      CALU_ROTATE_RIGHT_VIA_CARRY};
    calu_op_type bops [8] = '{CALU_BIT_SET_OP, CALU_BIT_CLEAR_OP,
      CALU_BIT_INVERT_OP, CALU_BIT_TEST_OP, CALU_CARRY_AND_BIT,
      CALU_CARRY_AND_INV_BIT, CALU_CARRY_OR_BIT, CALU_CARRY_OR_INV_BIT};
    calu_op_type eops [6] = '{CALU_SIGN_EXTEND_OP, CALU_DIVIDE_UNSIGNED,
      CALU_BIT_SET_OP, CALU_AND_OP, CALU_CARRY_AND_INV_BIT,
      CALU_CARRY_OR_INV_BIT};
    int esz [6] = '{0, 2, 1, 3, 0, 0};
    calu_cmd_type c;
    logic [31:0] r, b;
    logic [7:0] x;
    logic co;
    int t, w, d, bn;
    longint n, dv, lim, q, rm;
    reset = 1'b1;
    rd_idx = 3'h0;
    mismatches = 0;
    num_checks = 0;
    mc = CCR_RESET[CCR_C];
    void'($urandom(32'h277a8a02));
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (d = 0; d < 8; d++) begin
      m_reg[d] = GREG_RESET;
      chkreg(d);
      setr(d, $urandom);
    end
    $display("test reset done");
    for (t = 0; t < 150; t++) begin
      c = base(ops[$urandom_range(11)], $urandom_range(2), $urandom_range(7));
      c.src_idx = 3'($urandom_range(7));
      c.use_imm = 1'($urandom);
      c.imm = $urandom;
      if (c.size != CALU_SZ_L) c.dst_hi = 1'($urandom);
      if (c.size != CALU_SZ_L) c.src_hi = 1'($urandom);
      w = 8 << c.size;
      b = c.use_imm ? c.imm : m_reg[c.src_idx] >> (c.src_hi ? w : 0);
      ref_op(c.op, w, c.dst_hi ? w : 0, m_reg[c.dst_idx], b, r, co);
      dec.issue(c, rs);
      m_reg[c.dst_idx] = r;
      chkreg(c.dst_idx);
      if (c.op >= CALU_ARITH_SHIFT_LEFT) begin
        mc = co;
        chk_bit("carry", mc, condition_code_register[CCR_C]);
      end
    end
    $display("test logic and shift done");
    for (t = 0; t < 8; t++) begin
      c = base(t[0] ? CALU_SIGN_EXTEND_OP : CALU_ZERO_EXTEND_OP, 1 + t[1], t);
      w = t[1] ? 16 : 8;
      r = m_reg[t];
      for (d = w; d < 2 * w; d++) r[d] = t[0] & r[w-1];
      dec.issue(c, rs);
      m_reg[t] = r;
      chkreg(t);
    end
    for (t = 0; t < 6; t++) begin
      d = $urandom_range(7);
      c = base(CALU_COMPARE_OP, t % 3, d);
      c.use_imm = 1'b1;
      c.imm = (t < 3) ? m_reg[d] : $urandom;
      w = 8 << c.size;
      // flags come from the sized field only
      r = m_reg[d] & (32'hffff_ffff >> (32 - w));
      b = c.imm & (32'hffff_ffff >> (32 - w));
      dec.issue(c, rs);
      chkreg(d);
      chk_bit("zero", r == b, condition_code_register[CCR_Z]);
      chk_bit("carry", b > r, condition_code_register[CCR_C]);
      c.op = CALU_NEGATE_OP;
      ref_op(CALU_NEGATE_OP, w, 0, m_reg[d], 32'h0, r, mc);
      dec.issue(c, rs);
      m_reg[d] = r;
      chkreg(d);
    end
    $display("test extend compare negate done");
    for (t = 0; t < 16; t++) begin
      lim = t[1] ? 32767 : 127;
      if (!t[0]) begin
        dv = $urandom_range(t[1] ? 65535 : 255, 1);
        n = longint'($urandom_range(2 * lim + 1)) * dv;
        n = n + $urandom_range(dv - 1);
      end else begin
        dv = $urandom_range(lim, 1);
        n = longint'($urandom_range(2 * lim * dv)) - lim * dv;
        if (t[2]) dv = -dv;
      end
      setr(1, 32'(n));
      setr(5, 32'(dv));
      q = n / dv;
      rm = n % dv;
      r = m_reg[1];
      if (t[1]) r = {16'(rm), 16'(q)};
      else r[15:0] = {8'(rm), 8'(q)};
      c = base(t[0] ? CALU_DIVIDE_SIGNED : CALU_DIVIDE_UNSIGNED, t[1], 1);
      c.src_idx = 3'h5;
      dec.issue(c, rs);
      chk_bit("done", 1'b1, rs.done);
      chk_bit("busy", 1'b0, rs.busy);
      m_reg[1] = r;
      chkreg(1);
    end
    $display("test divide done");
    for (t = 0; t < 48; t++) begin
      c = base(bops[t % 8], 0, 3);
      c.imm = $urandom;
      c.mem_op = t[3];
      c.mem_byte = $urandom;
      c.src_idx = 3'h6;
      c.bit_from_reg = t[4] && !(t % 8 inside {5, 7});
      bn = c.bit_from_reg ? m_reg[6][2:0] : c.imm[2:0];
      x = c.mem_op ? c.mem_byte : m_reg[3][7:0];
      co = x[bn];
      if (t % 8 == 0) x[bn] = 1'b1;
      if (t % 8 == 1) x[bn] = 1'b0;
      if (t % 8 == 2) x[bn] = ~x[bn];
      if (t % 8 == 4) mc = mc & co;
      if (t % 8 == 5) mc = mc & ~co;
      if (t % 8 == 6) mc = mc | co;
      if (t % 8 == 7) mc = mc | ~co;
      dec.issue(c, rs);
      if (t % 8 < 3)
        chk_bit("mem write", c.mem_op, rs.mem_we);
      if (t % 8 < 3 && c.mem_op) begin
        chk_val("mem byte", {24'h0, x}, {24'h0, rs.mem_wdata});
      end else if (t % 8 < 3) begin
        m_reg[3][7:0] = x;
      end
      if (t % 8 == 3) chk_bit("zero", ~co, condition_code_register[CCR_Z]);
      if (t % 8 > 3) chk_bit("carry", mc, condition_code_register[CCR_C]);
      chkreg(3);
    end
    $display("test bit ops done");
    for (t = 0; t < 6; t++) begin
      c = base(eops[t], esz[t], 2);
      c.bit_from_reg = (t > 3);
      dec.issue(c, rs);
      chk_bit("error", 1'b1, rs.error);
      chkreg(2);
    end
    $display("test refused sizes done");
    close_out();
  end

  // whole run needs some 1350 cycles; over seven times that means a hang
  initial begin
    #100us;
    mismatches++;
    $display("Error watchdog expected end seen hang");
    close_out();
  end
endmodule
`default_nettype wire
